// ===== verilog/bsr_consts.svh
// Constants of the boundary scan registers: widths, codes, cell positions.
// Assumes inclusion by its bare name from the package and the design modules.
`ifndef BSR_CONSTS_SVH
`define BSR_CONSTS_SVH

// ==========================================================================
// Register widths
`define BSR_IR_W        3
`define BSR_ID_W        32
`define BSR_BND_W       107

// ==========================================================================
// Instruction codes
`define BSR_OP_EXTEST   3'h0
`define BSR_OP_IDCODE   3'h1
`define BSR_OP_SAMPLEZ  3'h2
`define BSR_OP_SAMPLE   3'h4
`define BSR_OP_BYPASS   3'h7
`define BSR_IR_CAPTURE  3'h1

// ==========================================================================
// Identification word fields
`define BSR_ID_REV_MSB  31
`define BSR_ID_REV_LSB  28
`define BSR_ID_PART_MSB 27
`define BSR_ID_PART_LSB 12
`define BSR_ID_VEND_MSB 11
`define BSR_ID_VEND_LSB 1
`define BSR_ID_FIX_BIT  0

// ==========================================================================
// Boundary cells, index is cell number minus one
`define BSR_CELL_WSEL0  54
`define BSR_CELL_INTERN 47

// ==========================================================================
// Timing
`define BSR_TLR_EDGES   5

`endif

// ===== verilog/bsr_pkg.sv
// Types shared by the boundary scan registers and their test port controller.
// Assumes the constants header is on the include path.
`include "bsr_consts.svh"

package bsr_pkg;

	// ======================================================================
	// Test port controller states
	typedef enum logic [3:0]
	{
		TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PAU_DR, EX2_DR, UPD_DR,
		SEL_IR, CAP_IR, SH_IR, EX1_IR, PAU_IR, EX2_IR, UPD_IR
	} bsr_tap_e;

	// ======================================================================
	// Word handed from the test clock domain to the system clock domain
	typedef struct packed
	{
		logic                    extest;
		logic                    dq_float;
		logic [`BSR_BND_W-1:0]   cells;
	} bsr_xfer_s;

endpackage

// ===== verilog/bsr_tap_ctrl.sv
// Test port controller: sixteen state machine stepped by the mode select.
// Assumes mode select is launched by the tester in step with the test clock.
`timescale 1ns/100ps
`include "bsr_consts.svh"

module bsr_tap_ctrl
(
	// Test port
	input  wire logic               tck,
	input  wire logic               rst_n,
	input  wire logic               tms,
	// Controller state
	output bsr_pkg::bsr_tap_e       state
);

	typedef struct packed
	{
		bsr_pkg::bsr_tap_e st;
	} bsr_ctl_s;

	bsr_ctl_s r;
	bsr_ctl_s next_r;

	// ======================================================================
	// Next state
	always_comb
	begin
		next_r = r;
		unique case (r.st)
			bsr_pkg::TLR:    next_r.st = tms ? bsr_pkg::TLR    : bsr_pkg::RTI;
			bsr_pkg::RTI:    next_r.st = tms ? bsr_pkg::SEL_DR : bsr_pkg::RTI;
			bsr_pkg::SEL_DR: next_r.st = tms ? bsr_pkg::SEL_IR : bsr_pkg::CAP_DR;
			bsr_pkg::CAP_DR: next_r.st = tms ? bsr_pkg::EX1_DR : bsr_pkg::SH_DR;
			bsr_pkg::SH_DR:  next_r.st = tms ? bsr_pkg::EX1_DR : bsr_pkg::SH_DR;
			bsr_pkg::EX1_DR: next_r.st = tms ? bsr_pkg::UPD_DR : bsr_pkg::PAU_DR;
			bsr_pkg::PAU_DR: next_r.st = tms ? bsr_pkg::EX2_DR : bsr_pkg::PAU_DR;
			bsr_pkg::EX2_DR: next_r.st = tms ? bsr_pkg::UPD_DR : bsr_pkg::SH_DR;
			bsr_pkg::UPD_DR: next_r.st = tms ? bsr_pkg::SEL_DR : bsr_pkg::RTI;
			bsr_pkg::SEL_IR: next_r.st = tms ? bsr_pkg::TLR    : bsr_pkg::CAP_IR;
			bsr_pkg::CAP_IR: next_r.st = tms ? bsr_pkg::EX1_IR : bsr_pkg::SH_IR;
			bsr_pkg::SH_IR:  next_r.st = tms ? bsr_pkg::EX1_IR : bsr_pkg::SH_IR;
			bsr_pkg::EX1_IR: next_r.st = tms ? bsr_pkg::UPD_IR : bsr_pkg::PAU_IR;
			bsr_pkg::PAU_IR: next_r.st = tms ? bsr_pkg::EX2_IR : bsr_pkg::PAU_IR;
			bsr_pkg::EX2_IR: next_r.st = tms ? bsr_pkg::UPD_IR : bsr_pkg::SH_IR;
			bsr_pkg::UPD_IR: next_r.st = tms ? bsr_pkg::SEL_DR : bsr_pkg::RTI;
		endcase
	end

	// There is no test reset pin, so power-up reset is the only way in besides mode select.
	always_ff @(posedge tck or negedge rst_n)
	begin
		if (!rst_n)
			r <= '{st: bsr_pkg::TLR};
		else
			r <= next_r;
	end

	assign state = r.st;

	// ======================================================================
	// Checks
	tlr_after_five_a: assert property (
		@(posedge tck) disable iff (!rst_n)
		tms [*5] |=> (state == bsr_pkg::TLR))
		else $error("Five high mode selects did not reach test logic reset.");

endmodule

// ===== verilog/bsr_scan_regs.sv
// Boundary scan registers of the memory device behind its four-wire test port.
// Assumes the pin sense inputs are steady around a capture, as for any boundary scan.
`timescale 1ns/100ps
`include "bsr_consts.svh"

module bsr_scan_regs
#(
	parameter logic [3:0]  ID_REVISION = 4'h0,
	parameter logic [15:0] ID_PART     = 16'h0a5c, // Arbitrary value.
	parameter logic [10:0] ID_VENDOR   = 11'h2b3   // Arbitrary value.
)
(
	// System side
	input  wire logic                   mclk,
	input  wire logic                   rst_n,
	// Test port
	input  wire logic                   tck,
	input  wire logic                   tms,
	input  wire logic                   tdi,
	output logic                        tdo,
	output logic                        tdo_en,
	// Pins sensed by the boundary cells, index is cell number minus one
	input  wire logic [`BSR_BND_W-1:0]  pin_sense,
	input  wire logic                   write_byte_select_0,
	// Pin control in the system clock domain
	output logic [`BSR_BND_W-1:0]       pin_drive_value,
	output logic                        pin_drive_en,
	output logic                        dq_float
);

	localparam logic [`BSR_ID_W-1:0] ID_WORD =
		{ID_REVISION, ID_PART, ID_VENDOR, 1'b1};

	// ======================================================================
	// Decoding
	function automatic logic uses_boundary(input logic [`BSR_IR_W-1:0] op);
		uses_boundary = (op == `BSR_OP_EXTEST) || (op == `BSR_OP_SAMPLEZ) ||
			(op == `BSR_OP_SAMPLE);
	endfunction

	function automatic logic [`BSR_BND_W-1:0] capture_cells(
		input logic [`BSR_BND_W-1:0] pins,
		input logic                  wsel0);
		logic [`BSR_BND_W-1:0] v;
		v = pins;
		v[`BSR_CELL_WSEL0]  = wsel0;
		v[`BSR_CELL_INTERN] = 1'b0;
		capture_cells = v;
	endfunction

	// ======================================================================
	// Controller
	bsr_pkg::bsr_tap_e state;

	bsr_tap_ctrl u_ctrl
	(
		.tck   (tck),
		.rst_n (rst_n),
		.tms   (tms),
		.state (state)
	);

	// ======================================================================
	// Scan registers, test clock rising edge
	typedef struct packed
	{
		logic [`BSR_IR_W-1:0]  ir;
		logic [`BSR_IR_W-1:0]  ir_sh;
		logic [`BSR_ID_W-1:0]  idr;
		logic [`BSR_BND_W-1:0] bnd;
		logic                  byp;
		bsr_pkg::bsr_xfer_s    xfer;
		logic                  tgl;
	} bsr_scan_s;

	bsr_scan_s t;
	bsr_scan_s next_t;

	always_comb
	begin
		next_t = t;
		unique case (state)
			bsr_pkg::TLR:
			begin
				next_t.ir = `BSR_OP_IDCODE;
				if (t.xfer.extest || t.xfer.dq_float)
				begin
					next_t.xfer.extest   = 1'b0;
					next_t.xfer.dq_float = 1'b0;
					next_t.tgl           = ~t.tgl;
				end
			end
			bsr_pkg::CAP_IR:
				next_t.ir_sh = `BSR_IR_CAPTURE;
			bsr_pkg::SH_IR:
				next_t.ir_sh = {tdi, t.ir_sh[`BSR_IR_W-1:1]};
			bsr_pkg::UPD_IR:
			begin
				next_t.ir            = t.ir_sh;
				next_t.xfer.extest   = (t.ir_sh == `BSR_OP_EXTEST);
				next_t.xfer.dq_float = (t.ir_sh == `BSR_OP_SAMPLEZ);
				next_t.tgl           = ~t.tgl;
			end
			bsr_pkg::CAP_DR:
			begin
				if (t.ir == `BSR_OP_IDCODE)
					next_t.idr = ID_WORD;
				else if (uses_boundary(t.ir))
					next_t.bnd = capture_cells(pin_sense, write_byte_select_0);
				else
					next_t.byp = 1'b0;
			end
			bsr_pkg::SH_DR:
			begin
				// Cell 1 sits next to the output and leaves first.
				if (t.ir == `BSR_OP_IDCODE)
					next_t.idr = {tdi, t.idr[`BSR_ID_W-1:1]};
				else if (uses_boundary(t.ir))
					next_t.bnd = {tdi, t.bnd[`BSR_BND_W-1:1]};
				else
					next_t.byp = tdi;
			end
			bsr_pkg::UPD_DR:
			begin
				if (uses_boundary(t.ir))
				begin
					next_t.xfer.cells = t.bnd;
					next_t.tgl        = ~t.tgl;
				end
			end
			default:
				next_t = t;
		endcase
	end

	always_ff @(posedge tck or negedge rst_n)
	begin
		if (!rst_n)
			t <= '{ir: `BSR_OP_IDCODE, default: '0};
		else
			t <= next_t;
	end

	// ======================================================================
	// Serial output, test clock falling edge
	typedef struct packed
	{
		logic tdo;
		logic tdo_en;
	} bsr_out_s;

	bsr_out_s o;
	bsr_out_s next_o;

	always_comb
	begin
		next_o        = o;
		next_o.tdo_en = (state == bsr_pkg::SH_IR) || (state == bsr_pkg::SH_DR);
		if (state == bsr_pkg::SH_IR)
			next_o.tdo = t.ir_sh[0];
		else if (state == bsr_pkg::SH_DR)
		begin
			if (t.ir == `BSR_OP_IDCODE)
				next_o.tdo = t.idr[0];
			else if (uses_boundary(t.ir))
				next_o.tdo = t.bnd[0];
			else
				next_o.tdo = t.byp;
		end
	end

	// Launching on the falling edge gives the next device a half period of setup.
	always_ff @(negedge tck or negedge rst_n)
	begin
		if (!rst_n)
			o <= '0;
		else
			o <= next_o;
	end

	assign tdo    = o.tdo;
	assign tdo_en = o.tdo_en;

	// ======================================================================
	// Pin control, system clock domain
	typedef struct packed
	{
		logic [2:0]            sync;
		logic                  last;
		logic [`BSR_BND_W-1:0] drive;
		logic                  drive_en;
		logic                  dq_float;
	} bsr_sys_s;

	bsr_sys_s s;
	bsr_sys_s next_s;

	// The word is taken only once the toggle has settled, so it has been steady for
	// at least two system clocks. Updates must therefore be a few test clocks apart.
	always_comb
	begin
		next_s      = s;
		next_s.sync = {s.sync[1:0], t.tgl};
		if ((s.sync[1] == s.sync[2]) && (s.sync[2] != s.last))
		begin
			next_s.last     = s.sync[2];
			next_s.drive    = t.xfer.cells;
			next_s.drive_en = t.xfer.extest;
			next_s.dq_float = t.xfer.dq_float;
		end
	end

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			s <= '0;
		else
			s <= next_s;
	end

	assign pin_drive_value = s.drive;
	assign pin_drive_en    = s.drive_en;
	assign dq_float        = s.dq_float;

	// ======================================================================
	// Checks
	ir_preload_a: assert property (
		@(posedge tck) disable iff (!rst_n)
		(state == bsr_pkg::TLR) |=> (t.ir == `BSR_OP_IDCODE))
		else $error("Instruction not preset to identification in reset state.");

	ir_capture_a: assert property (
		@(posedge tck) disable iff (!rst_n)
		(state == bsr_pkg::CAP_IR) ##1 (state == bsr_pkg::SH_IR) [*3]
		|=> (t.ir_sh == {$past(tdi, 1), $past(tdi, 2), $past(tdi, 3)}))
		else $error("Instruction register did not take three shifted bits.");

	id_capture_a: assert property (
		@(posedge tck) disable iff (!rst_n)
		(state == bsr_pkg::CAP_DR && t.ir == `BSR_OP_IDCODE) |=> (t.idr == ID_WORD))
		else $error("Identification code not loaded at capture.");

	id_fields_a: assert property (
		@(posedge tck) disable iff (!rst_n)
		(state == bsr_pkg::CAP_DR && t.ir == `BSR_OP_IDCODE) |=>
		(t.idr[`BSR_ID_REV_MSB:`BSR_ID_REV_LSB] == ID_REVISION &&
		t.idr[`BSR_ID_PART_MSB:`BSR_ID_PART_LSB] == ID_PART &&
		t.idr[`BSR_ID_VEND_MSB:`BSR_ID_VEND_LSB] == ID_VENDOR))
		else $error("Identification fields misplaced.");

	id_lsb_a: assert property (
		@(posedge tck) disable iff (!rst_n)
		(state == bsr_pkg::CAP_DR && t.ir == `BSR_OP_IDCODE) ##1 (state == bsr_pkg::SH_DR)
		|-> (tdo == 1'b1))
		else $error("First identification bit out is not one.");

	tdo_ir_path_a: assert property (
		@(posedge tck) disable iff (!rst_n)
		(state == bsr_pkg::SH_IR) |-> (tdo == t.ir_sh[0] && tdo_en))
		else $error("Serial output not launched on the falling edge.");

	bypass_path_a: assert property (
		@(posedge tck) disable iff (!rst_n)
		(state == bsr_pkg::SH_DR && t.ir == `BSR_OP_BYPASS) |=> (t.byp == $past(tdi)))
		else $error("Bypass bit did not take the serial input.");

	cell55_capture_a: assert property (
		@(posedge tck) disable iff (!rst_n)
		(state == bsr_pkg::CAP_DR && t.ir == `BSR_OP_SAMPLE) |=>
		(t.bnd[`BSR_CELL_WSEL0] == $past(write_byte_select_0)))
		else $error("Cell 55 did not sample the write select.");

	cell48_internal_a: assert property (
		@(posedge tck) disable iff (!rst_n)
		(state == bsr_pkg::CAP_DR && uses_boundary(t.ir)) |=> !t.bnd[`BSR_CELL_INTERN])
		else $error("Internal cell 48 captured a pin.");

endmodule

// ===== verif/bsr_tester.sv
// Behavioural boundary-scan tester that drives the test clock, mode select and serial data.
// Assumes the scan registers sample on the rising and launch on the falling test clock.
`timescale 1ns/100ps

module bsr_tester
(
	// Test port
	output logic      tck,
	output logic      tms,
	output logic      tdi,
	input  wire logic tdo
);
	// ======================================================================
	// Idle levels
	// The test clock stands still low between frames, so nothing shifts by accident.
	initial
	begin
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b0;
	end

	// ======================================================================
	// One test clock period of 15 ns; output is sampled just before the rising edge.
	task automatic step(input logic m, input logic d, output logic o);
		tms = m;
		tdi = d;
		#4;
		o = tdo;
		tck = 1'b1;
		#7.5;
		tck = 1'b0;
		#3.5;
	endtask

	// ======================================================================
	// Full scan from idle to idle, least significant bit first.
	task automatic scan(input logic ir, input logic [127:0] din, input int n,
		output logic [127:0] dout);
		logic o;
		dout = '0;
		step(1'b1, 1'b0, o);
		if (ir)
			step(1'b1, 1'b0, o);
		step(1'b0, 1'b0, o);
		step(1'b0, 1'b0, o);
		for (int i = 0; i < n; i++)
		begin
			step(i == n - 1, din[i], o);
			dout[i] = o;
		end
		step(1'b1, 1'b0, o);
		step(1'b0, 1'b0, o);
	endtask

	// ======================================================================
	// Five high mode selects reach test logic reset, then back to idle.
	task automatic reset5();
		logic o;
		repeat (5) step(1'b1, 1'b0, o);
		step(1'b0, 1'b0, o);
	endtask
endmodule

// ===== verif/bsr_scan_regs_tb_top.sv
// Self-checking testbench of the boundary scan registers.
// Assumes the tester model drives the test port and this module the system side.
`timescale 1ns/100ps
`include "bsr_consts.svh"

module bsr_scan_regs_tb_top;
	localparam logic [3:0]  REV  = 4'h3;    // Arbitrary value.
	localparam logic [15:0] PART = 16'h1234; // Arbitrary value.
	localparam logic [10:0] VEND = 11'h155;  // Arbitrary value.
	localparam logic [31:0] ID_WORD = {REV, PART, VEND, 1'b1};

	logic         mclk;
	logic         rst_n;
	logic         tck;
	logic         tms;
	logic         tdi;
	logic         tdo;
	logic         tdo_en;
	logic         wsel0;
	logic         pin_drive_en;
	logic         dq_float;
	logic [106:0] pin_sense;
	logic [106:0] pin_drive_value;
	logic [127:0] got;
	int           err_total;
	int           checks;

	// ======================================================================
	// Instances
	bsr_scan_regs #(.ID_REVISION(REV), .ID_PART(PART), .ID_VENDOR(VEND)) i_bsr_scan_regs
	(
		.mclk(mclk), .rst_n(rst_n), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
		.tdo_en(tdo_en), .pin_sense(pin_sense), .write_byte_select_0(wsel0),
		.pin_drive_value(pin_drive_value), .pin_drive_en(pin_drive_en), .dq_float(dq_float)
	);

	bsr_tester i_bsr_tester(.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));

	always #10 mclk = ~mclk;

	// ======================================================================
	// Helpers
	task automatic chk(input logic [127:0] g, input logic [127:0] e);
		checks++;
		if (g !== e)
		begin
			err_total++;
			$display("unexpected at %0t ns: got %h expected %h", $time, g, e);
		end
	endtask

	// Mode changes cross to the system clock in a few cycles.
	task automatic settle();
		repeat (8) @(posedge mclk);
	endtask

	task automatic end_of_test();
		$display("checks %0d err_total %0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// The serial output must never move while the test clock is high.
	always @(tdo)
		if (rst_n === 1'b1 && tck !== 1'b0)
		begin
			err_total++;
			$display("unexpected at %0t ns: got %h expected %h", $time, tck, 1'b0);
		end

	// ======================================================================
	// Scenarios
	task automatic t_bypass();
		logic [2:0] ops [4] = '{3'h3, 3'h5, 3'h6, `BSR_OP_BYPASS};
		foreach (ops[k])
		begin
			i_bsr_tester.scan(1'b1, {125'h0, ops[k]}, 3, got);
			chk(got, 128'h1);
			i_bsr_tester.scan(1'b0, 128'h5, 4, got);
			chk(got, 128'ha);
		end
	endtask

	task automatic t_bound();
		logic [106:0] d;
		logic [106:0] e;
		d = {{53{2'b10}}, 1'b0};
		e = {{53{2'b01}}, 1'b1};
		@(posedge mclk);
		pin_sense <= e;
		wsel0     <= 1'b1;
		e[54] = 1'b1;
		e[47] = 1'b0;
		i_bsr_tester.scan(1'b1, {125'h0, `BSR_OP_SAMPLE}, 3, got);
		i_bsr_tester.scan(1'b0, {21'h0, d}, 107, got);
		chk(got, {21'h0, e});
		settle();
		chk({21'h0, pin_drive_value}, {21'h0, d});
		chk({126'h0, pin_drive_en, dq_float}, 128'h0);
		i_bsr_tester.scan(1'b1, {125'h0, `BSR_OP_EXTEST}, 3, got);
		settle();
		chk({126'h0, pin_drive_en, dq_float}, 128'h2);
		i_bsr_tester.scan(1'b1, {125'h0, `BSR_OP_SAMPLEZ}, 3, got);
		settle();
		chk({126'h0, pin_drive_en, dq_float}, 128'h1);
		i_bsr_tester.reset5();
		settle();
		chk({126'h0, pin_drive_en, dq_float}, 128'h0);
	endtask

	// ======================================================================
	// Main sequence
	initial
	begin
		mclk = 1'b0;
		rst_n = 1'b0;
		wsel0 = 1'b0;
		pin_sense = '0;
		err_total = 0;
		checks = 0;
		i_bsr_tester.step(1'b1, 1'b0, got[0]);
		repeat (3) @(posedge mclk);
		rst_n <= 1'b1;
		@(posedge mclk);
		chk({19'h0, pin_drive_value, pin_drive_en, dq_float}, 128'h0);
		i_bsr_tester.step(1'b0, 1'b0, got[0]);
		i_bsr_tester.scan(1'b0, 128'h0, 32, got);
		chk(got, {96'h0, ID_WORD});
		chk({127'h0, tdo_en}, 128'h0);
		t_bypass();
		i_bsr_tester.reset5();
		i_bsr_tester.scan(1'b0, 128'h0, 32, got);
		chk(got, {96'h0, ID_WORD});
		t_bound();
		end_of_test();
	end

	initial
	begin
		#200000;
		err_total++;
		end_of_test();
	end
endmodule
